// ===== hw/fdc_regs.sv
//  Purpose: I2C-reached control register bank of a single-LED flash driver, with flash triggering and timeout
//  Assumes: One 40 MHz clock; every pin passes two flip-flops before use
//  Notes:   Open-drain SDA is three signals; the enclosing pad logic resolves the wire
`timescale 1ns/1ps
`include "fdc_map.svh"

module fdc_regs
  import fdc_pkg::*;
#(
  // Arbitrary identification value
  parameter logic [7:0] DESIGN_INFO = 8'h5A,
  parameter int unsigned TIMEOUT_STEP_CYCLES =
    32'(64'(`FDC_TIMEOUT_STEP_MS) * 64'(`FDC_CLK_HZ) / 64'd1000)
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Device pins
  input wire logic enable_pin,
  input wire logic trigger_pin,
  input wire logic aux_pin_a,
  input wire logic aux_pin_b,
  // I2C
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Power stage control
  output fdc_ctrl_t ctrl,
  output logic timeout_event
);

  // ***********************************
  // Pin synchronisers
  // ***********************************
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic [4:0] pin_prev;
  logic scl_s, sda_s, en_s, trig_s, aux_a_s, aux_b_s;
  logic scl_q, sda_q, en_q, trig_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      // Enable idles high; its stages reset high so no false rise follows reset
      pin_meta <= 5'h02;
      pin_sync <= 5'h02;
      pin_prev <= 5'h02;
    end else begin
      pin_meta <= {aux_pin_b, aux_pin_a, trigger_pin, enable_pin, scl & sda_in ? 1'b1 : 1'b0};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Separate SCL/SDA stages so both lines are seen individually
  logic [1:0] bus_meta;
  logic [1:0] bus_sync;
  logic [1:0] bus_prev;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_meta <= 2'h3;
      bus_sync <= 2'h3;
      bus_prev <= 2'h3;
    end else begin
      bus_meta <= {scl, sda_in};
      bus_sync <= bus_meta;
      bus_prev <= bus_sync;
    end
  end

  assign scl_s = bus_sync[1];
  assign sda_s = bus_sync[0];
  assign scl_q = bus_prev[1];
  assign sda_q = bus_prev[0];
  assign en_s = pin_sync[1];
  assign en_q = pin_prev[1];
  assign trig_s = pin_sync[2];
  assign trig_q = pin_prev[2];
  assign aux_a_s = pin_sync[3];
  assign aux_b_s = pin_sync[4];

  logic scl_rise, scl_fall, bus_start, bus_stop, en_rise;
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
  assign bus_stop = scl_s & scl_q & ~sda_q & sda_s;
  assign en_rise = en_s & ~en_q;

  // ***********************************
  // Register storage
  // ***********************************
  logic [7:0] pin_config_and_timer, next_pin_config_and_timer;
  logic [7:0] current_setting, next_current_setting;
  logic [7:0] output_mode, next_output_mode;
  fdc_i2c_t bus, next_bus;

  function automatic logic [7:0] read_reg(input logic [7:0] off, input logic [7:0] r_pin,
                                          input logic [7:0] r_cur, input logic [7:0] r_mode);
    case (off)
      `FDC_OFF_INFO: read_reg = DESIGN_INFO;
      `FDC_OFF_PINTIM: read_reg = r_pin;
      `FDC_OFF_CURR: read_reg = r_cur;
      `FDC_OFF_MODE: read_reg = r_mode;
      default: read_reg = 8'h00;
    endcase
  endfunction : read_reg

  // ***********************************
  // I2C slave
  // ***********************************
  always_comb begin
    next_bus = bus;
    next_bus.wr_stb = 1'b0;
    if (bus_stop) begin
      next_bus.state = FDC_ST_IDLE;
      next_bus.sda_oe = 1'b0;
    end else if (bus_start) begin
      next_bus.state = FDC_ST_ADDR;
      next_bus.bitcnt = 4'h0;
      next_bus.sda_oe = 1'b0;
    end else begin
      case (bus.state)
        FDC_ST_ADDR, FDC_ST_SUB, FDC_ST_WRITE: begin
          if (scl_rise && bus.bitcnt != 4'h8) begin
            // MSB arrives first, so shifting left puts bit 7 on top
            next_bus.shreg = {bus.shreg[6:0], sda_s};
            next_bus.bitcnt = bus.bitcnt + 4'h1;
          end else if (scl_fall && bus.bitcnt == 4'h8) begin
            next_bus.bitcnt = 4'h0;
            next_bus.sda_oe = 1'b1;
            if (bus.state == FDC_ST_ADDR) begin
              if (bus.shreg[7:1] == `FDC_I2C_ADDR) begin
                next_bus.rw = bus.shreg[0];
                next_bus.state = FDC_ST_ACK_ADDR;
              end else begin
                next_bus.sda_oe = 1'b0;
                next_bus.state = FDC_ST_IDLE;
              end
            end else if (bus.state == FDC_ST_SUB) begin
              next_bus.ptr = bus.shreg;
              next_bus.state = FDC_ST_ACK_SUB;
            end else begin
              next_bus.wr_stb = 1'b1;
              next_bus.state = FDC_ST_ACK_WRITE;
            end
          end
        end
        FDC_ST_ACK_ADDR, FDC_ST_ACK_SUB, FDC_ST_ACK_WRITE: begin
          if (scl_fall) begin
            next_bus.sda_oe = 1'b0;
            next_bus.bitcnt = 4'h0;
            if (bus.state == FDC_ST_ACK_ADDR && bus.rw) begin
              next_bus.shreg = read_reg(bus.ptr, pin_config_and_timer, current_setting, output_mode);
              next_bus.sda_oe = ~next_bus.shreg[7];
              next_bus.state = FDC_ST_READ;
            end else if (bus.state == FDC_ST_ACK_ADDR) begin
              next_bus.state = FDC_ST_SUB;
            end else begin
              // Auto-increment lets a burst fill consecutive registers
              if (bus.state == FDC_ST_ACK_WRITE) begin
                next_bus.ptr = bus.ptr + 8'h01;
              end
              next_bus.state = FDC_ST_WRITE;
            end
          end
        end
        FDC_ST_READ: begin
          if (scl_fall) begin
            next_bus.bitcnt = bus.bitcnt + 4'h1;
            if (bus.bitcnt == 4'h7) begin
              next_bus.sda_oe = 1'b0;
              next_bus.state = FDC_ST_ACK_READ;
            end else begin
              next_bus.shreg = {bus.shreg[6:0], 1'b0};
              next_bus.sda_oe = ~bus.shreg[6];
            end
          end
        end
        FDC_ST_ACK_READ: begin
          if (scl_rise) begin
            if (sda_s) begin
              next_bus.state = FDC_ST_IDLE;
            end else begin
              next_bus.ptr = bus.ptr + 8'h01;
            end
          end else if (scl_fall) begin
            next_bus.bitcnt = 4'h0;
            next_bus.shreg = read_reg(bus.ptr, pin_config_and_timer, current_setting, output_mode);
            next_bus.sda_oe = ~next_bus.shreg[7];
            next_bus.state = FDC_ST_READ;
          end
        end
        default: begin
          next_bus.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus <= '{state: FDC_ST_IDLE, bitcnt: 4'h0, shreg: 8'h00, ptr: 8'h00, rw: 1'b0, sda_oe: 1'b0,
               wr_stb: 1'b0};
    end else begin
      bus <= next_bus;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = bus.sda_oe;

  // ***********************************
  // Flash trigger and timeout
  // ***********************************
  logic edge_armed, next_edge_armed;
  logic [31:0] timer, next_timer;
  logic flash_want, flash_active, expire;
  logic [31:0] limit;
  logic flash_mode;

  assign flash_mode = output_mode[`FDC_B_OUT_EN] && output_mode[`FDC_F_LED_MODE] == FDC_LED_FLASH;
  // Level sensing follows the pin; edge sensing latches a rising edge until timeout
  always_comb begin
    if (!output_mode[`FDC_B_SOURCE]) begin
      flash_want = flash_mode;
    end else if (output_mode[`FDC_B_SENSE]) begin
      flash_want = flash_mode & trig_s;
    end else begin
      flash_want = flash_mode & edge_armed;
    end
  end

  assign limit = (32'(pin_config_and_timer[`FDC_F_TIMEOUT]) + 32'h1) * TIMEOUT_STEP_CYCLES;
  assign flash_active = flash_want;
  assign expire = flash_active && timer == limit - 32'h1;

  always_comb begin
    next_timer = flash_active && !expire ? timer + 32'h1 : 32'h0;
    next_edge_armed = edge_armed;
    // A rise seen outside hardware edge mode must not arm a later flash
    if (!flash_mode || expire || output_mode[`FDC_B_SENSE] || !output_mode[`FDC_B_SOURCE]) begin
      next_edge_armed = 1'b0;
    end else if (trig_s && !trig_q) begin
      next_edge_armed = 1'b1;
    end
  end

  // ***********************************
  // Register writes
  // ***********************************
  always_comb begin
    next_pin_config_and_timer = pin_config_and_timer;
    next_current_setting = current_setting;
    next_output_mode = output_mode;
    if (en_rise) begin
      next_pin_config_and_timer = `FDC_RST_PINTIM;
      next_current_setting = `FDC_RST_CURR;
      next_output_mode = `FDC_RST_MODE;
    end else begin
      if (bus.wr_stb) begin
        // Offset 0x00 and unmapped offsets fall through untouched
        case (bus.ptr)
          `FDC_OFF_PINTIM: next_pin_config_and_timer = bus.shreg;
          `FDC_OFF_CURR: next_current_setting = bus.shreg;
          `FDC_OFF_MODE: next_output_mode = bus.shreg;
          default: next_output_mode = output_mode;
        endcase
      end
      // Timeout shuts the output so a stuck trigger cannot hold the LED on
      if (expire) begin
        next_output_mode[`FDC_B_OUT_EN] = 1'b0;
      end
    end
  end

  fdc_ctrl_t next_ctrl;
  fdc_pin_fn_t fn_a, fn_b;
  assign fn_a = fdc_pin_fn_t'(pin_config_and_timer[`FDC_F_PIN_A]);
  assign fn_b = fdc_pin_fn_t'(pin_config_and_timer[`FDC_F_PIN_B]);

  always_comb begin
    next_ctrl.flash_on = flash_active; // Held through the expiring cycle for a full timeout
    next_ctrl.assist_on = output_mode[`FDC_B_OUT_EN] && output_mode[`FDC_F_LED_MODE] == FDC_LED_ASSIST;
    next_ctrl.boost_5v_on = output_mode[`FDC_B_OUT_EN] && output_mode[`FDC_F_LED_MODE] == FDC_LED_VOLTAGE;
    next_ctrl.torch_on = fn_a == FDC_PIN_TORCH_OR_IND && aux_a_s;
    next_ctrl.rf_mask_a = fn_a == FDC_PIN_RF_MASK && aux_a_s;
    next_ctrl.indicator_on = fn_b == FDC_PIN_TORCH_OR_IND;
    next_ctrl.rf_mask_b = fn_b == FDC_PIN_RF_MASK && aux_b_s;
    next_ctrl.adc_route = fn_b == FDC_PIN_ANALOG;
    next_ctrl.fallback_allow = output_mode[`FDC_B_FALLBACK];
    next_ctrl.peak_limit = output_mode[`FDC_F_PEAK];
    next_ctrl.flash_current = current_setting[`FDC_F_FLASH_CUR];
    next_ctrl.torch_current = current_setting[`FDC_F_TORCH_CUR];
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_config_and_timer <= `FDC_RST_PINTIM;
      current_setting <= `FDC_RST_CURR;
      output_mode <= `FDC_RST_MODE;
      timer <= 32'h0;
      edge_armed <= 1'b0;
      ctrl <= '0;
      timeout_event <= 1'b0;
    end else begin
      pin_config_and_timer <= next_pin_config_and_timer;
      current_setting <= next_current_setting;
      output_mode <= next_output_mode;
      timer <= next_timer;
      edge_armed <= next_edge_armed;
      ctrl <= next_ctrl;
      timeout_event <= expire;
    end
  end

endmodule : fdc_regs

// ===== hw/fdc_map.svh
//  Purpose: Offsets, field positions, reset values and timing figures of the flash driver register bank
//  Assumes: Included by its bare name by the package and the design module
//  Notes:   Multi-bit field positions are written as msb:lsb and single bits as an index, so that they can be used directly as selects
`ifndef FDC_MAP_SVH
`define FDC_MAP_SVH

// ***********************************
// Bus address and register offsets
// ***********************************
`define FDC_I2C_ADDR 7'h30
`define FDC_OFF_INFO 8'h00
`define FDC_OFF_PINTIM 8'h02
`define FDC_OFF_CURR 8'h03
`define FDC_OFF_MODE 8'h04

// ***********************************
// Reset values
// ***********************************
`define FDC_RST_PINTIM 8'h0F
`define FDC_RST_CURR 8'h73
`define FDC_RST_MODE 8'hA4

// ***********************************
// Field positions
// ***********************************
`define FDC_F_PIN_B 7:6
`define FDC_F_PIN_A 5:4
`define FDC_F_TIMEOUT 3:0
`define FDC_F_FLASH_CUR 7:3
`define FDC_F_TORCH_CUR 2:0
`define FDC_F_PEAK 7:6
`define FDC_B_SENSE 5
`define FDC_B_FALLBACK 4
`define FDC_B_OUT_EN 3
`define FDC_B_SOURCE 2
`define FDC_F_LED_MODE 1:0

// ***********************************
// Timing
// ***********************************
`define FDC_CLK_HZ 40000000
`define FDC_TIMEOUT_STEP_MS 100

`endif

// ===== hw/fdc_pkg.sv
//  Purpose: Types shared by the flash driver register bank
//  Assumes: fdc_map.svh holds every number except the enum code values set here
//  Notes:   Code values of the mode fields match the register encodings
package fdc_pkg;
  `include "fdc_map.svh"

  typedef enum logic [1:0] {
    FDC_LED_STANDBY = 2'h0,
    FDC_LED_VOLTAGE = 2'h1,
    FDC_LED_ASSIST = 2'h2,
    FDC_LED_FLASH = 2'h3
  } fdc_led_mode_t;

  typedef enum logic [1:0] {
    FDC_PIN_HIZ = 2'h0,
    FDC_PIN_TORCH_OR_IND = 2'h1,
    FDC_PIN_RF_MASK = 2'h2,
    FDC_PIN_ANALOG = 2'h3
  } fdc_pin_fn_t;

  typedef enum {
    FDC_ST_IDLE, FDC_ST_ADDR, FDC_ST_ACK_ADDR, FDC_ST_SUB, FDC_ST_ACK_SUB,
    FDC_ST_WRITE, FDC_ST_ACK_WRITE, FDC_ST_READ, FDC_ST_ACK_READ
  } fdc_i2c_state_t;

  typedef struct packed {
    fdc_i2c_state_t state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic rw;
    logic sda_oe;
    logic wr_stb;
  } fdc_i2c_t;

  typedef struct packed {
    logic flash_on;
    logic assist_on;
    logic torch_on;
    logic boost_5v_on;
    logic indicator_on;
    logic adc_route;
    logic rf_mask_a;
    logic rf_mask_b;
    logic fallback_allow;
    logic [1:0] peak_limit;
    logic [4:0] flash_current;
    logic [2:0] torch_current;
  } fdc_ctrl_t;
endpackage : fdc_pkg

// ===== dv/fdc_regs_asserts.sv
// Purpose: Port-level checks of the flash driver register bank
// Assumes: Bound to fdc_regs; one clock domain
// Notes: Flash run limit follows the timeout step parameter
`timescale 1ns/1ps
module fdc_regs_asserts
  import fdc_pkg::*;
#(
  parameter int unsigned TIMEOUT_STEP_CYCLES = 10
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Watched ports
  input wire logic enable_pin,
  input wire logic scl,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire fdc_ctrl_t ctrl,
  input wire logic timeout_event
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ***********************************
  // Flash run length
  // ***********************************
  logic [31:0] on_run;
  logic [31:0] next_on_run;
  always_comb next_on_run = ctrl.flash_on ? on_run + 32'h1 : 32'h0;
  always_ff @(posedge sys_clk) on_run <= rst ? 32'h0 : next_on_run;
  sequence s_scl_high;
    scl [*7];
  endsequence
  sequence s_defaults;
    ctrl.peak_limit == 2'h2 && ctrl.flash_current == 5'h0E && ctrl.torch_current == 3'h3;
  endsequence
  property p_reset_quiet;
    $fell(rst) |-> ctrl == '0 && !sda_oe && !timeout_event;
  endproperty
  property p_pulse;
    timeout_event |=> !timeout_event;
  endproperty
  property p_timeout_off;
    timeout_event |-> ##[0:2] !ctrl.flash_on;
  endproperty
  property p_event_after_flash;
    timeout_event |-> $past(ctrl.flash_on);
  endproperty
  property p_flash_len;
    on_run <= 32'(16 * TIMEOUT_STEP_CYCLES + 2);
  endproperty
  property p_mode_excl;
    $onehot0({ctrl.flash_on, ctrl.assist_on, ctrl.boost_5v_on});
  endproperty
  property p_pin_b_excl;
    $onehot0({ctrl.indicator_on, ctrl.rf_mask_b, ctrl.adc_route});
  endproperty
  property p_pin_a_excl;
    !(ctrl.torch_on && ctrl.rf_mask_a);
  endproperty
  property p_open_drain;
    sda_out == 1'b0;
  endproperty
  property p_ack_stable;
    s_scl_high |-> $stable(sda_oe);
  endproperty
  property p_enable_reload;
    $rose(enable_pin) |-> ##[3:6] s_defaults;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet after reset");
  a_pulse: assert property (p_pulse) else $error("timeout pulse too long");
  a_timeout_off: assert property (p_timeout_off) else $error("flash stays on after timeout");
  a_flash_len: assert property (p_flash_len) else $error("flash outlasts longest timeout");
  a_event_after_flash: assert property (p_event_after_flash) else $error("timeout without flash");
  a_mode_excl: assert property (p_mode_excl) else $error("two output modes at once");
  a_pin_b_excl: assert property (p_pin_b_excl) else $error("second pin has two functions");
  a_pin_a_excl: assert property (p_pin_a_excl) else $error("first pin has two functions");
  a_open_drain: assert property (p_open_drain) else $error("data line driven high");
  a_ack_stable: assert property (p_ack_stable) else $error("data changed while clock high");
  a_enable_reload: assert property (p_enable_reload) else $error("enable rise did not reload");
endmodule : fdc_regs_asserts

bind fdc_regs fdc_regs_asserts #(.TIMEOUT_STEP_CYCLES(TIMEOUT_STEP_CYCLES)) fdc_regs_asserts_i (
  .sys_clk(sys_clk), .rst(rst), .enable_pin(enable_pin), .scl(scl), .sda_out(sda_out),
  .sda_oe(sda_oe), .ctrl(ctrl), .timeout_event(timeout_event));

// ===== dv/fdc_host_model.sv
// Purpose: I2C host that reaches the flash driver registers
// Assumes: Data line has a pull-up resolved by the bench
// Notes: Clock stands high between transfers; high time 8 cycles
`timescale 1ns/1ps
module fdc_host_model (
  // Clock
  input wire logic sys_clk,
  // I2C
  input wire logic sda_wire,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : hold
  // ***********************************
  // Bus conditions
  // ***********************************
  // Also serves as repeated start
  task automatic start();
    sda_low <= 1'b0;
    hold(5);
    scl <= 1'b1;
    hold(8);
    sda_low <= 1'b1;
    hold(5);
    scl <= 1'b0;
    hold(5);
  endtask : start
  task automatic stop();
    sda_low <= 1'b1;
    hold(5);
    scl <= 1'b1;
    hold(8);
    sda_low <= 1'b0;
    hold(8);
  endtask : stop
  // Eight bits MSB first plus the acknowledge bit
  task automatic byte9(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_low <= !tx[i];
      hold(5);
      scl <= 1'b1;
      hold(8);
      rx[i] = sda_wire;
      scl <= 1'b0;
      hold(3);
    end
  endtask : byte9
  task automatic write_reg(input logic [7:0] adr, input logic [7:0] off, input logic [7:0] dat, output logic ok);
    logic [8:0] a, b, c;
    start();
    byte9({adr, 1'b1}, a);
    byte9({off, 1'b1}, b);
    byte9({dat, 1'b1}, c);
    stop();
    ok = !a[0] && !b[0] && !c[0];
  endtask : write_reg
  task automatic read_reg(input logic [7:0] off, output logic [7:0] dat);
    logic [8:0] a, b, c, d;
    start();
    byte9({8'h60, 1'b1}, a);
    byte9({off, 1'b1}, b);
    start();
    byte9({8'h61, 1'b1}, c);
    byte9(9'h1FF, d);
    stop();
    dat = d[8:1];
  endtask : read_reg
endmodule : fdc_host_model

// ===== dv/test_flash_driver_control_regs.sv
// Purpose: Register and control checks of the flash driver bank
// Assumes: Host model speaks I2C; timeout step shortened to 10 cycles
// Notes: Counters are never cleared; scenarios compare differences
`timescale 1ns/1ps
module test_flash_driver_control_regs;
  import fdc_pkg::*;
  localparam logic [7:0] INFO = 8'h3C; // Arbitrary identification value
  localparam int STEP = 10;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic enable_pin = 1'b1;
  logic trigger_pin = 1'b0;
  logic aux_pin_a = 1'b1;
  logic aux_pin_b = 1'b1;
  logic scl, sda_low, sda_out, sda_oe, timeout_event, ok;
  wire logic sda_wire = !(sda_low || sda_oe);
  fdc_ctrl_t ctrl;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int on_cycles = 0;
  int events = 0;
  int base, ev;
  fdc_regs #(.DESIGN_INFO(INFO), .TIMEOUT_STEP_CYCLES(STEP)) fdc_regs_i (.sys_clk(sys_clk), .rst(rst),
    .enable_pin(enable_pin), .trigger_pin(trigger_pin), .aux_pin_a(aux_pin_a), .aux_pin_b(aux_pin_b),
    .scl(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .ctrl(ctrl), .timeout_event(timeout_event));
  fdc_host_model fdc_host_model_i (.sys_clk(sys_clk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));
  initial forever #12.5 sys_clk = ~sys_clk;
  // ***********************************
  // Tasks and monitor
  // ***********************************
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] off, input logic [7:0] dat);
    fdc_host_model_i.write_reg(8'h60, off, dat, ok);
    chk({7'h0, ok}, 8'h01);
  endtask : wr
  task automatic rd_chk(input logic [7:0] off, input logic [7:0] exp);
    logic [7:0] v;
    fdc_host_model_i.read_reg(off, v);
    chk(v, exp);
  endtask : rd_chk
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (ctrl.flash_on === 1'b1) on_cycles <= on_cycles + 1;
    if (timeout_event === 1'b1) events <= events + 1;
    if (cycles == 40000) begin
      mismatches++;
      $display("ERROR %0t: run did not finish", $time);
      stop_test();
    end
  end
  // ***********************************
  // Scenarios
  // ***********************************
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd_chk(8'h00, INFO);
    rd_chk(8'h01, 8'h00);
    rd_chk(8'h02, 8'h0F);
    rd_chk(8'h03, 8'h73);
    rd_chk(8'h04, 8'hA4);
    wr(8'h00, 8'hFF);
    wr(8'h01, 8'hFF);
    rd_chk(8'h00, INFO);
    rd_chk(8'h01, 8'h00);
    fdc_host_model_i.write_reg(8'h62, 8'h03, 8'h00, ok);
    chk({7'h0, ok}, 8'h00);
    rd_chk(8'h03, 8'h73);
    wr(8'h03, 8'h2E);
    chk({ctrl.flash_current, ctrl.torch_current}, 8'h2E);
    rd_chk(8'h03, 8'h2E);
    wr(8'h02, 8'h01);
    for (int m = 0; m < 3; m++) begin
      wr(8'h04, 8'h98 | 8'(m));
      chk({ctrl.boost_5v_on, ctrl.assist_on, ctrl.fallback_allow, ctrl.peak_limit, 3'h0},
        {m == 1, m == 2, 1'b1, 2'h2, 3'h0});
    end
    base = on_cycles;
    ev = events;
    wr(8'h04, 8'h9B);
    repeat (10) @(posedge sys_clk);
    chk(8'((on_cycles - base) inside {[2 * STEP:2 * STEP + 1]}), 8'h01);
    chk(8'(events - ev), 8'h01);
    rd_chk(8'h04, 8'h93);
    wr(8'h04, 8'hBF);
    base = on_cycles;
    repeat (20) @(posedge sys_clk);
    chk(8'(on_cycles - base), 8'h00);
    trigger_pin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    trigger_pin <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk(8'(on_cycles - base), 8'h08);
    wr(8'h04, 8'h9F);
    base = on_cycles;
    ev = events;
    repeat (10) @(posedge sys_clk);
    chk(8'(on_cycles - base), 8'h00);
    trigger_pin <= 1'b1;
    repeat (2) @(posedge sys_clk);
    trigger_pin <= 1'b0;
    repeat (30) @(posedge sys_clk);
    chk(8'((on_cycles - base) inside {[2 * STEP:2 * STEP + 1]}), 8'h01);
    chk(8'(events - ev), 8'h01);
    rd_chk(8'h04, 8'h97);
    for (int c = 1; c < 4; c++) begin
      wr(8'h02, 8'(c * 80 + 1));
      chk({ctrl.indicator_on, ctrl.rf_mask_b, ctrl.adc_route, ctrl.rf_mask_a, ctrl.torch_on, 3'h0},
        {c == 1, c == 2, c == 3, c == 2, c == 1, 3'h0});
    end
    enable_pin <= 1'b0;
    repeat (5) @(posedge sys_clk);
    enable_pin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rd_chk(8'h02, 8'h0F);
    rd_chk(8'h03, 8'h73);
    rd_chk(8'h04, 8'hA4);
    wr(8'h03, 8'h11);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd_chk(8'h03, 8'h73);
    stop_test();
  end
endmodule : test_flash_driver_control_regs
